// ### common/crfbr_pkg.sv
/*
  shared constants and carriers for the receive filter routing block.
  assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package crfbr_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned AXI_AW        = 8;
  localparam logic [7:0]  OFS_ENABLE    = 8'h00;
  localparam logic [7:0]  OFS_PTR_4_7   = 8'h04;
  localparam logic [7:0]  OFS_PTR_8_11  = 8'h08;
  localparam logic [7:0]  OFS_PTR_12_15 = 8'h0C;
  localparam logic [7:0]  OFS_STATUS    = 8'h10;

  // ------------------------------------------------------------
  // reset values and field layout
  // ------------------------------------------------------------
  localparam logic [15:0] ENABLE_RST    = 16'hFFFF;
  localparam logic [15:0] PTR_RST       = 16'h0000;
  localparam logic [3:0]  DEST_FIFO     = 4'hF;
  localparam int unsigned FLD_W         = 4;
  localparam int unsigned NUM_FILTERS   = 16;
  localparam int unsigned FILTER_4      = 4;
  localparam int unsigned FIRST_PTR3    = 8;
  localparam int unsigned FIRST_PTR4    = 12;
  localparam int unsigned GROUP         = 4;

  // ------------------------------------------------------------
  // bus responses
  // ------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [3:0] filter;
  } crfbr_hit_s;

  typedef struct packed {
    logic       toFifo;
    logic [3:0] filter;
    logic [3:0] buffer;
  } crfbr_route_s;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [15:0] data;
    logic [1:0]  strb;
  } crfbr_wr_s;

endpackage

// ### rtl/crfbr_axi_slave.sv
/*
  AXI4-Lite slave front end: takes address and data in either order,
  hands one write pulse to the register file, registers read data.
  assumes the register file decodes addresses combinationally.
*/
`timescale 1ns/1ps
module crfbr_axi_slave
  import crfbr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic              rready,
  output logic                   rvalid,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  input  wire logic [31:0]       rdData,
  input  wire logic              rdOk,
  input  wire logic              wrOk,
  output crfbr_wr_s              wr
);

  // ------------------------------------------------------------
  // handshakes
  // ------------------------------------------------------------
  logic        awHeld_r;
  logic        wHeld_r;
  logic [7:0]  awAddr_r;
  logic [15:0] wData_r;
  logic [1:0]  wStrb_r;
  logic        awHs;
  logic        wHs;
  logic        bHs;
  logic        arHs;
  logic        rHs;
  logic        doWrite;

  assign awHs    = awvalid && awready;
  assign wHs     = wvalid && wready;
  assign bHs     = bvalid && bready;
  assign arHs    = arvalid && arready;
  assign rHs     = rvalid && rready;
  assign doWrite = awHeld_r && wHeld_r;
  assign wr      = '{en: doWrite, addr: awAddr_r, data: wData_r,
                     strb: wStrb_r};

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  // ready stays low until the response is taken: one write in flight
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      awready  <= 1'h1;
      wready   <= 1'h1;
      awHeld_r <= 1'h0;
      wHeld_r  <= 1'h0;
      awAddr_r <= 8'h00;
      wData_r  <= 16'h0000;
      wStrb_r  <= 2'h0;
      bvalid   <= 1'h0;
      bresp    <= RESP_OKAY;
    end
    else
    begin
      if (awHs)
      begin
        awready  <= 1'h0;
        awHeld_r <= 1'h1;
        awAddr_r <= awaddr;
      end
      if (wHs)
      begin
        wready  <= 1'h0;
        wHeld_r <= 1'h1;
        wData_r <= wdata[15:0];
        wStrb_r <= wstrb[1:0];
      end
      if (doWrite)
      begin
        awHeld_r <= 1'h0;
        wHeld_r  <= 1'h0;
        bvalid   <= 1'h1;
        bresp    <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end
      if (bHs)
      begin
        bvalid  <= 1'h0;
        awready <= 1'h1;
        wready  <= 1'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      arready <= 1'h1;
      rvalid  <= 1'h0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end
    else if (arHs)
    begin
      arready <= 1'h0;
      rvalid  <= 1'h1;
      rdata   <= rdData;
      rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rHs)
    begin
      arready <= 1'h1;
      rvalid  <= 1'h0;
    end
  end

endmodule // crfbr_axi_slave

// ### rtl/crfbr_route_sel.sv
/*
  per-filter destination lookup: picks the pointer nibble of the
  hitting filter and qualifies the hit with its enable bit.
  assumes pointers exist only for filter 4 and filters 8 to 15.
*/
`timescale 1ns/1ps
module crfbr_route_sel
  import crfbr_pkg::*;
(
  input  wire logic [15:0] enable,
  input  wire logic [3:0]  ptr4,
  input  wire logic [15:0] ptr811,
  input  wire logic [15:0] ptr1215,
  input  wire crfbr_hit_s  hit,
  output logic             accept,
  output logic [3:0]       selPtr
);

  logic [NUM_FILTERS*FLD_W-1:0] ptrTab;
  logic [NUM_FILTERS-1:0]       held;

  genvar f;
  generate
    for (f = 0; f < NUM_FILTERS; f++)
    begin : g_flt
      if (f == FILTER_4)
      begin : g_f4
        assign ptrTab[f*FLD_W +: FLD_W] = ptr4;
        assign held[f] = 1'h1;
      end
      else if (f >= FIRST_PTR3 && f < FIRST_PTR3 + GROUP)
      begin : g_p3
        assign ptrTab[f*FLD_W +: FLD_W] =
          ptr811[(f-FIRST_PTR3)*FLD_W +: FLD_W];
        assign held[f] = 1'h1;
      end
      else if (f >= FIRST_PTR4)
      begin : g_p4
        assign ptrTab[f*FLD_W +: FLD_W] =
          ptr1215[(f-FIRST_PTR4)*FLD_W +: FLD_W];
        assign held[f] = 1'h1;
      end
      else
      begin : g_none
        // these filters have no pointer anywhere, so their hits are never accepted
        assign ptrTab[f*FLD_W +: FLD_W] = 4'h0;
        assign held[f] = 1'h0;
      end
    end
  endgenerate

  assign selPtr = ptrTab[hit.filter*FLD_W +: FLD_W];
  assign accept = hit.valid && enable[hit.filter] && held[hit.filter];

endmodule // crfbr_route_sel

// ### rtl/crfbr_top.sv
/*
  receive filter routing: destination pointer registers, filter
  enables and the routing decision for each accepted message.
  assumes the matcher presents one hit per cycle at most, and an
  AXI4-Lite master on the register side.
*/
`timescale 1ns/1ps
module crfbr_top
  import crfbr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [AXI_AW-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  input  wire crfbr_hit_s        hit,
  output logic                   routeValid_r,
  output crfbr_route_s           route_r
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic regHit(input logic [7:0] a);
    regHit = (a == OFS_ENABLE) || (a == OFS_PTR_4_7) ||
             (a == OFS_PTR_8_11) || (a == OFS_PTR_12_15) ||
             (a == OFS_STATUS);
  endfunction

  function automatic logic [15:0] mergeStrb(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0]  strb);
    mergeStrb = {strb[1] ? nw[15:8] : old[15:8],
                 strb[0] ? nw[7:0]  : old[7:0]};
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0]  enable_r;
  logic [15:0]  enable_nxt;
  logic [3:0]   ptr4_r;
  logic [3:0]   ptr4_nxt;
  logic [15:0]  ptr811_r;
  logic [15:0]  ptr811_nxt;
  logic [15:0]  ptr1215_r;
  logic [15:0]  ptr1215_nxt;
  logic         seen_r;
  logic         seen_nxt;
  crfbr_route_s route_nxt;

  crfbr_wr_s    wrReq;
  logic         wrOk;
  logic         rdOk;
  logic [31:0]  rdData;
  logic [31:0]  statusWord;
  logic         accept;
  logic [3:0]   selPtr;
  logic         enableWr;
  logic         ptr4Wr;
  logic         ptr811Wr;
  logic         ptr1215Wr;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  crfbr_axi_slave u_axi (
    .clk     (clk),
    .nrst    (nrst),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .rready  (rready),
    .rvalid  (rvalid),
    .rdata   (rdata),
    .rresp   (rresp),
    .rdData  (rdData),
    .rdOk    (rdOk),
    .wrOk    (wrOk),
    .wr      (wrReq)
  );

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  assign wrOk      = regHit(wrReq.addr);
  assign rdOk      = regHit(araddr);
  assign enableWr  = wrReq.en && (wrReq.addr == OFS_ENABLE);
  assign ptr4Wr    = wrReq.en && (wrReq.addr == OFS_PTR_4_7);
  assign ptr811Wr  = wrReq.en && (wrReq.addr == OFS_PTR_8_11);
  assign ptr1215Wr = wrReq.en && (wrReq.addr == OFS_PTR_12_15);

  assign enable_nxt  = enableWr ?
                       mergeStrb(enable_r, wrReq.data, wrReq.strb) :
                       enable_r;
  // only the filter 4 nibble of that word is kept here
  assign ptr4_nxt    = (ptr4Wr && wrReq.strb[0]) ?
                       wrReq.data[3:0] : ptr4_r;
  assign ptr811_nxt  = ptr811Wr ?
                       mergeStrb(ptr811_r, wrReq.data, wrReq.strb) :
                       ptr811_r;
  assign ptr1215_nxt = ptr1215Wr ?
                       mergeStrb(ptr1215_r, wrReq.data, wrReq.strb) :
                       ptr1215_r;

  assign statusWord = {22'h000000, seen_r, route_r};
  assign rdData = (araddr == OFS_ENABLE)    ? {16'h0000, enable_r}  :
                  (araddr == OFS_PTR_4_7)   ? {28'h0000000, ptr4_r} :
                  (araddr == OFS_PTR_8_11)  ? {16'h0000, ptr811_r}  :
                  (araddr == OFS_PTR_12_15) ? {16'h0000, ptr1215_r} :
                  (araddr == OFS_STATUS)    ? statusWord            :
                  32'h00000000;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enable_r  <= ENABLE_RST;
      ptr4_r    <= PTR_RST[3:0];
      ptr811_r  <= PTR_RST;
      ptr1215_r <= PTR_RST;
    end
    else
    begin
      enable_r  <= enable_nxt;
      ptr4_r    <= ptr4_nxt;
      ptr811_r  <= ptr811_nxt;
      ptr1215_r <= ptr1215_nxt;
    end
  end

  // ------------------------------------------------------------
  // routing
  // ------------------------------------------------------------
  crfbr_route_sel u_sel (
    .enable  (enable_r),
    .ptr4    (ptr4_r),
    .ptr811  (ptr811_r),
    .ptr1215 (ptr1215_r),
    .hit     (hit),
    .accept  (accept),
    .selPtr  (selPtr)
  );

  // a pointer written in the hit cycle applies to the next message
  assign route_nxt = accept ?
                     '{toFifo: (selPtr == DEST_FIFO),
                       filter: hit.filter,
                       buffer: selPtr} :
                     route_r;
  assign seen_nxt  = seen_r || accept;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      routeValid_r <= 1'h0;
      route_r      <= '0;
      seen_r       <= 1'h0;
    end
    else
    begin
      routeValid_r <= accept;
      route_r      <= route_nxt;
      seen_r       <= seen_nxt;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_fifo_on_ones: assert property (
    accept && (selPtr == DEST_FIFO) |=> routeValid_r && route_r.toFifo)
    else $error("all-ones pointer did not route to fifo");

  a_buffer_number: assert property (
    accept && (selPtr != DEST_FIFO) |=>
      routeValid_r && !route_r.toFifo && route_r.buffer == $past(selPtr))
    else $error("buffer number differs from pointer");

  a_filter11_field: assert property (
    accept && (hit.filter == 4'hB) |=>
      route_r.buffer == $past(ptr811_r[15:12]))
    else $error("filter 11 not taken from bits 15-12");

  a_filter8_field: assert property (
    accept && (hit.filter == 4'h8) |=>
      route_r.buffer == $past(ptr811_r[3:0]))
    else $error("filter 8 not taken from bits 3-0");

  a_filter9_field: assert property (
    accept && (hit.filter == 4'h9) |=>
      route_r.buffer == $past(ptr811_r[7:4]))
    else $error("filter 9 not taken from bits 7-4");

  a_filter4_field: assert property (
    accept && (hit.filter == 4'h4) |=> route_r.buffer == $past(ptr4_r))
    else $error("filter 4 not taken from its nibble");

  a_filter15_field: assert property (
    accept && (hit.filter == 4'hF) |=>
      route_r.buffer == $past(ptr1215_r[15:12]))
    else $error("filter 15 not taken from bits 15-12");

  a_filter14_field: assert property (
    accept && (hit.filter == 4'hE) |=>
      route_r.buffer == $past(ptr1215_r[11:8]))
    else $error("filter 14 not taken from bits 11-8");

  a_filter13_field: assert property (
    accept && (hit.filter == 4'hD) |=>
      route_r.buffer == $past(ptr1215_r[7:4]))
    else $error("filter 13 not taken from bits 7-4");

  a_filter12_field: assert property (
    accept && (hit.filter == 4'hC) |=>
      route_r.buffer == $past(ptr1215_r[3:0]))
    else $error("filter 12 not taken from bits 3-0");

  a_disabled_filter: assert property (
    hit.valid && !enable_r[hit.filter] |=> !routeValid_r)
    else $error("disabled filter produced a route");

  a_pointer_sampled: assert property (
    routeValid_r |-> route_r.filter == $past(hit.filter) &&
                     route_r.buffer == $past(selPtr))
    else $error("route not sampled at acceptance");

  a_ptr_readback: assert property (
    arvalid && arready && (araddr == OFS_PTR_8_11) |=>
      rvalid && rdata == {16'h0000, $past(ptr811_r)})
    else $error("pointer readback mismatch");

  a_ptr_write: assert property (
    wrReq.en && (wrReq.addr == OFS_PTR_12_15) && (wrReq.strb == 2'h3)
      |=> ptr1215_r == $past(wrReq.data) ##0 bvalid)
    else $error("pointer write not stored");

  a_resp_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped before taken");

  a_ptr4_write: assert property (
    ptr4Wr && wrReq.strb[0] |=> ptr4_r == $past(wrReq.data[3:0]))
    else $error("filter 4 pointer write not stored");

  a_route_hold: assert property (
    !accept |=> !routeValid_r && $stable(route_r))
    else $error("route changed without an accepted hit");

  a_status_sticky: assert property (
    seen_r |=> seen_r)
    else $error("accept flag dropped");

  a_unpointed_filter: assert property (
    hit.valid && (hit.filter < FIRST_PTR3) && (hit.filter != FILTER_4)
      |=> !routeValid_r)
    else $error("filter without a pointer produced a route");

  c_fifo_route: cover property (
    accept && (selPtr == DEST_FIFO) ##1 routeValid_r);
  c_buffer_route: cover property (
    accept && (selPtr == 4'hE) ##1 routeValid_r);
  c_disabled_hit: cover property (
    hit.valid && !enable_r[hit.filter]);
  c_write_then_hit: cover property (
    ptr811Wr ##[1:4] accept && (hit.filter == 4'h9));

endmodule // crfbr_top

// ### verif/crfbr_hit_source.sv
/*
  far-side model: stands in for the acceptance matcher fed by can
  nodes, turning a bench request into a one-cycle hit pulse.
  assumes the same clock and reset as the routing block.
*/
`timescale 1ns/1ps
module crfbr_hit_source
  import crfbr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       req,
  input  wire logic [3:0] reqFilter,
  output crfbr_hit_s      hit
);
  // ------------------------------------------------------------
  // hit pipe
  // ------------------------------------------------------------
  // idle filter field toggles so a stale value never looks valid
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hit <= '0;
    else
    begin
      hit.valid  <= req;
      hit.filter <= req ? reqFilter : ~hit.filter;
    end
  end
endmodule // crfbr_hit_source

// ### verif/crfbr_top_tb.sv
/*
  self-checking bench for the routing block: axi4-lite master tasks,
  register and route models, random and corner stimulus.
  assumes crfbr_top and crfbr_hit_source are compiled beside it.
*/
`timescale 1ns/1ps
module crfbr_top_tb
  import crfbr_pkg::*;
;
  // ------------------------------------------------------------
  // signals and models
  // ------------------------------------------------------------
  logic         clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid, routeValid_r;
  logic         req, chkOn, pendV, anyE, lateR;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, seed;
  logic [3:0]   wstrb, reqF;
  logic [1:0]   bresp, rresp;
  crfbr_hit_s   hit;
  crfbr_route_s route_r, pendR, lastR;
  logic [3:0]   ptrE [16];
  logic [15:0]  enE;
  logic [7:0]   tbl [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                            8'h20, 8'hFC};
  int           n_fail, cmp_count;

  always #12.5 clk = ~clk;

  crfbr_top uut (.clk(clk), .nrst(nrst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .hit(hit),
    .routeValid_r(routeValid_r), .route_r(route_r));

  crfbr_hit_source src (.clk(clk), .nrst(nrst), .req(req),
    .reqFilter(reqF), .hit(hit));

  // ------------------------------------------------------------
  // expectation functions
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a <= OFS_STATUS) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic takes(input logic [3:0] f);
    return enE[f] && (f == 4'h4 || f >= 4'h8);
  endfunction

  function automatic logic [31:0] regE(input logic [7:0] a);
    case (a)
      OFS_ENABLE:    return {16'h0, enE};
      OFS_PTR_4_7:   return {28'h0, ptrE[4]};
      OFS_PTR_8_11:  return {16'h0, ptrE[11], ptrE[10], ptrE[9], ptrE[8]};
      OFS_PTR_12_15: return {16'h0, ptrE[15], ptrE[14], ptrE[13], ptrE[12]};
      OFS_STATUS:    return {22'h0, anyE, lastR};
      default:       return 32'h0;
    endcase
  endfunction

  // rotating pattern: filter 4 and filters 8 to 15 see every code over 16 passes
  function automatic logic [15:0] pat(input int v, input int base);
    logic [15:0] r;
    for (int k = 0; k < 4; k++)
      r[4*k +: 4] = 4'(v + base + k);
    return r;
  endfunction

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] o;
    logic [15:0] nw;
    o  = regE(a);
    nw = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1;
    wdata <= d; wstrb <= s; bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    chk("bresp", {30'h0, mapped(a) ? RESP_OKAY : RESP_SLVERR},
        {30'h0, bresp});
    bready <= 1'b0;
    case (a)
      OFS_ENABLE:    enE = nw;
      OFS_PTR_4_7:   ptrE[4] = nw[3:0];
      OFS_PTR_8_11:  for (int i = 0; i < 4; i++) ptrE[8+i] = nw[4*i +: 4];
      OFS_PTR_12_15: for (int i = 0; i < 4; i++) ptrE[12+i] = nw[4*i +: 4];
      default:       ;
    endcase
  endtask

  // every other read raises rready late, so the answer must stand
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= !lateR;
    lateR   = !lateR;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && !rready)
        rready <= 1'b1;
    end while (!(rvalid && rready));
    chk("rresp", {30'h0, mapped(a) ? RESP_OKAY : RESP_SLVERR},
        {30'h0, rresp});
    chk("rdata", regE(a), rdata);
    rready <= 1'b0;
  endtask

  // back-to-back hits, one each cycle
  task automatic hits(input int n, input logic rnd);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      req  <= 1'b1;
      reqF <= rnd ? seed[3:0] : 4'(i);
      seed = lfsr(seed);
    end
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // route monitor: pointer taken at the hit edge, pulse one later
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (chkOn)
    begin
      chk("routeValid", {31'h0, pendV}, {31'h0, routeValid_r});
      chk("route", {23'h0, pendV ? pendR : lastR},
          {23'h0, route_r});
      if (pendV)
      begin
        lastR = pendR;
        anyE  = 1'b1;
      end
      pendV = hit.valid && takes(hit.filter);
      pendR = {ptrE[hit.filter] == DEST_FIFO, hit.filter,
               ptrE[hit.filter]};
    end
  end

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    clk = 0; nrst = 0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    wstrb = 0; req = 0; reqF = 0; chkOn = 0; pendV = 0; anyE = 0;
    lateR = 0;
    lastR = '0; pendR = '0; enE = ENABLE_RST; seed = 32'h1BD8;
    n_fail = 0; cmp_count = 0;
    for (int i = 0; i < 16; i++) ptrE[i] = PTR_RST[3:0];
    repeat (20) @(posedge clk);
    nrst  <= 1'b1;
    chkOn <= 1'b1;
    for (int a = 0; a <= 24; a += 4) rd(8'(a));
    hits(16, 1'b0);
    for (int v = 0; v < 16; v++)
    begin
      for (int g = 1; g < 4; g++)
        wr(8'(4*g), {16'h0, pat(v, 4*g)}, 4'hF);
      for (int g = 1; g < 4; g++) rd(8'(4*g));
      hits(16, 1'b0);
    end
    for (int k = 0; k < 40; k++)
    begin
      seed = lfsr(seed);
      wr(tbl[seed[2:0]], lfsr(seed), seed[7:4]);
      rd(tbl[seed[2:0]]);
      hits(6, 1'b1);
    end
    wr(OFS_ENABLE, 32'h0, 4'hF);
    hits(16, 1'b0);
    wr(OFS_ENABLE, 32'hFFFF, 4'h3);
    rd(OFS_STATUS);
    results();
  end

  // whole run is about 1500 cycles; this is ample headroom
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    results();
  end
endmodule // crfbr_top_tb
